// ==== rtl/adcsr_top.sv ====
// converter channel, status and interrupt registers behind ahb-lite
// How it works
// - write one enables matching channel
// - write one disables matching channel
// - channel state shows enabled channels
// - done flag needs enabled and finished
// - channel overrun sets, clears on read
// - result flag sets, clears latest read
// - global overrun sets, clears on read
// - receive end once counter hit zero
// - buffer full while both counters zero
// - latest result holds last conversion
// - channel result loads only when enabled
// - irq set write sets mask bits
// - irq clear write clears mask bits
// - mask register reads enabled sources
// - resolution select ten or eight bits
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module adcsr_top
  import adcsr_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CONV_DONE,
  input wire logic [2:0] CONV_CHAN,
  input wire logic [9:0] CONV_VALUE,
  input wire logic CONV_OVERRUN,
  input wire logic CONV_GEN_OVERRUN,
  input wire logic RX_XFER,
  output logic [7:0] CHAN_ENABLE,
  output logic RESOLUTION_SELECT,
  output logic [15:0] RX_COUNT,
  output logic IRQ
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] mode;
    logic [NCH-1:0] chan_on;
    logic [NCH-1:0] done;
    logic [NCH-1:0] ovr;
    logic result_available_flag;
    logic govr;
    logic receive_end_flag;
    logic [NFLAG-1:0] mask;
    logic [DW-1:0] latest;
    logic [NCH-1:0][DW-1:0] result;
    logic [15:0] rcnt;
    logic [15:0] rncnt;
    logic [31:0] rdata;
    logic rd_wait;
  } adcsr_state_t;

  adcsr_state_t s_q;
  adcsr_state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  adcsr_conv_t conv;
  logic [NFLAG-1:0] flags;
  logic receive_buffer_full_flag;
  logic [31:0] rd_val;
  logic rd_first;

  // first data cycle of a read: hold the bus so read data is registered in time
  assign rd_first = rd_stb && !s_q.rd_wait;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  adcsr_ahb_slave u_slave (
    .clk(CLK),
    .rst_n(rst_n),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hready(HREADY),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr)
  );

  // cell inputs are same-clock logic, no synchroniser
  assign conv = '{done: CONV_DONE, chan: CONV_CHAN, value: CONV_VALUE,
                  overrun: CONV_OVERRUN, gen_overrun: CONV_GEN_OVERRUN};

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 8-bit mode keeps the low eight bits, upper ones zero
  function automatic logic [DW-1:0] fit_res(input logic resolution_select, input logic [DW-1:0] v);
    fit_res = resolution_select ? {2'b00, v[7:0]} : v;
  endfunction

  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= OFS_RESULT0) && (a <= OFS_RESULT7);
  endfunction

  assign receive_buffer_full_flag = (s_q.rcnt == CNT_RST) && (s_q.rncnt == CNT_RST);
  assign flags = {receive_buffer_full_flag, s_q.receive_end_flag, s_q.govr, s_q.result_available_flag, s_q.ovr, s_q.done};

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_result(addr)) begin
      rd_val = {22'h000000, s_q.result[3'(addr[4:2] - 3'h4)]};
    end else begin
      unique case (addr)
        OFS_MODE: rd_val = s_q.mode;
        OFS_CH_STATE: rd_val = {24'h000000, s_q.chan_on};
        OFS_FLAGS: rd_val = {12'h000, flags};
        OFS_LATEST: rd_val = {22'h000000, s_q.latest};
        OFS_IRQ_MASK: rd_val = {12'h000, s_q.mask};
        OFS_RX_CNT: rd_val = {16'h0000, s_q.rcnt};
        OFS_RX_NCNT: rd_val = {16'h0000, s_q.rncnt};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rd_wait = rd_first;
    // side effects only once per read, even though rd_stb spans two cycles
    if (rd_first) begin
      s_d.rdata = rd_val;
    end
    // clears first, hardware sets below win in the same cycle
    if (rd_first && addr == OFS_FLAGS) begin
      s_d.ovr = '0;
      s_d.govr = 1'b0;
    end
    if (rd_first && addr == OFS_LATEST) begin
      s_d.result_available_flag = 1'b0;
    end
    if (wr_stb) begin
      unique case (addr)
        OFS_MODE: s_d.mode = HWDATA;
        OFS_CH_ON: s_d.chan_on = s_q.chan_on | HWDATA[NCH-1:0];
        OFS_CH_OFF: s_d.chan_on = s_q.chan_on & ~HWDATA[NCH-1:0];
        OFS_IRQ_SET: s_d.mask = s_q.mask | HWDATA[NFLAG-1:0];
        OFS_IRQ_CLR: s_d.mask = s_q.mask & ~HWDATA[NFLAG-1:0];
        OFS_RX_CNT: begin
          s_d.rcnt = HWDATA[15:0];
          s_d.receive_end_flag = 1'b0;
        end
        OFS_RX_NCNT: begin
          s_d.rncnt = HWDATA[15:0];
          s_d.receive_end_flag = 1'b0;
        end
        default: s_d.mode = s_d.mode;
      endcase
    end
    // done flag drops when its channel is turned off
    s_d.done = s_d.done & s_d.chan_on;
    // dma counter: current drains, next reloads it
    if (RX_XFER && s_q.rcnt != CNT_RST) begin
      s_d.rcnt = s_q.rcnt - 16'h0001;
      if (s_q.rcnt == 16'h0001) begin
        s_d.receive_end_flag = 1'b1;
        s_d.rcnt = s_q.rncnt;
        s_d.rncnt = CNT_RST;
      end
    end
    if (conv.done) begin
      s_d.latest = fit_res(s_q.mode[POS_RESOLUTION_SELECT], conv.value);
      s_d.result_available_flag = 1'b1;
      if (s_q.chan_on[conv.chan]) begin
        s_d.result[conv.chan] = fit_res(s_q.mode[POS_RESOLUTION_SELECT], conv.value);
        s_d.done[conv.chan] = 1'b1;
      end
    end
    if (conv.done && rd_first && addr == OFS_RESULT0 + {conv.chan, 2'b00}) begin
      s_d.done[conv.chan] = s_d.done[conv.chan];
    end else if (rd_first && is_result(addr)) begin
      s_d.done[3'(addr[4:2] - 3'h4)] = 1'b0;
    end
    if (conv.overrun) begin
      s_d.ovr[conv.chan] = 1'b1;
    end
    if (conv.gen_overrun) begin
      s_d.govr = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      // counters reset to zero, so receive end reads set
      s_q.receive_end_flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = !rd_first;
  assign HRESP = 1'b0;
  assign CHAN_ENABLE = s_q.chan_on;
  assign RESOLUTION_SELECT = s_q.mode[POS_RESOLUTION_SELECT];
  assign RX_COUNT = s_q.rcnt;
  assign IRQ = |(flags & s_q.mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chan_on_a: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_stb && addr == OFS_CH_ON |=> (s_q.chan_on & $past(HWDATA[7:0])) == $past(HWDATA[7:0]))
    else $error("channel enable write lost");
  chan_off_a: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_stb && addr == OFS_CH_OFF |=> (s_q.chan_on & $past(HWDATA[7:0])) == 8'h00)
    else $error("channel disable write lost");
  done_needs_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (s_q.done & ~s_q.chan_on) == 8'h00)
    else $error("done flag on disabled channel");
  ovr_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
    rd_first && addr == OFS_FLAGS && !conv.overrun |=> s_q.ovr == 8'h00)
    else $error("overrun not cleared by read");
  result_available_flag_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    conv.done |=> s_q.result_available_flag)
    else $error("data ready not set");
  govr_a: assert property (@(posedge CLK) disable iff (!rst_n)
    conv.gen_overrun |=> s_q.govr)
    else $error("global overrun not set");
  latest_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !conv.done |=> $stable(s_q.latest))
    else $error("latest result changed without conversion");
  mask_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_stb && addr == OFS_IRQ_SET |=> (s_q.mask & $past(HWDATA[19:0])) == $past(HWDATA[19:0]))
    else $error("mask set lost");
  mask_clr_a: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_stb && addr == OFS_IRQ_CLR |=> (s_q.mask & $past(HWDATA[19:0])) == 20'h00000)
    else $error("mask clear lost");
  irq_a: assert property (@(posedge CLK) disable iff (!rst_n)
    s_q.result_available_flag && s_q.mask[POS_RESULT_AVAILABLE_FLAG] |-> IRQ)
    else $error("interrupt level wrong");
  irq_quiet_a: assert property (@(posedge CLK) disable iff (!rst_n)
    s_q.mask == 20'h00000 |-> !IRQ)
    else $error("interrupt with all sources masked");
  rd_wait_a: assert property (@(posedge CLK) disable iff (!rst_n)
    rd_stb && !s_q.rd_wait |-> !HREADYOUT)
    else $error("read wait state missing");
  receive_end_flag_clr_a: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_stb && addr == OFS_RX_CNT && !RX_XFER |=> !s_q.receive_end_flag)
    else $error("receive end not cleared by counter write");
  receive_end_flag_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    RX_XFER && s_q.rcnt == 16'h0001 |=> s_q.receive_end_flag)
    else $error("receive end not set");
  result_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
    conv.done && !s_q.chan_on[conv.chan] |=> $stable(s_q.result))
    else $error("result loaded on disabled channel");
  result_available_flag_clr_a: assert property (@(posedge CLK) disable iff (!rst_n)
    rd_first && addr == OFS_LATEST && !conv.done |=> !s_q.result_available_flag)
    else $error("data ready not cleared by read");
  govr_clr_a: assert property (@(posedge CLK) disable iff (!rst_n)
    rd_first && addr == OFS_FLAGS && !conv.gen_overrun |=> !s_q.govr)
    else $error("global overrun not cleared by read");
  low_res_a: assert property (@(posedge CLK) disable iff (!rst_n)
    conv.done && s_q.mode[POS_RESOLUTION_SELECT] |=> s_q.latest[DW-1:DW-2] == 2'b00)
    else $error("eight-bit result has upper bits set");
  chan_state_a: assert property (@(posedge CLK) disable iff (!rst_n)
    rd_first && addr == OFS_CH_STATE |=> HRDATA == {24'h000000, $past(s_q.chan_on)})
    else $error("channel state read wrong");
endmodule

// ==== rtl/adcsr_pkg.sv ====
// package: register map, field layout and carrier types of the converter register block
package adcsr_pkg;
  localparam int NCH = 8;
  localparam int DW = 10;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CH_ON = 8'h10;
  localparam logic [7:0] OFS_CH_OFF = 8'h14;
  localparam logic [7:0] OFS_CH_STATE = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_LATEST = 8'h20;
  localparam logic [7:0] OFS_IRQ_SET = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  localparam logic [7:0] OFS_RESULT0 = 8'h30;
  localparam logic [7:0] OFS_RESULT7 = 8'h4c;
  localparam logic [7:0] OFS_RX_CNT = 8'h50;
  localparam logic [7:0] OFS_RX_NCNT = 8'h54;
  localparam int POS_OVR = 8;
  localparam int POS_RESULT_AVAILABLE_FLAG = 16;
  localparam int POS_GOVR = 17;
  localparam int POS_RECEIVE_END_FLAG = 18;
  localparam int POS_RECEIVE_BUFFER_FULL_FLAG = 19;
  localparam int NFLAG = 20;
  localparam int POS_RESOLUTION_SELECT = 4;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  typedef struct packed {
    logic done;
    logic [2:0] chan;
    logic [DW-1:0] value;
    logic overrun;
    logic gen_overrun;
  } adcsr_conv_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } adcsr_req_t;
endpackage

// ==== rtl/adcsr_ahb_slave.sv ====
// ahb-lite slave front end: captures the address phase and issues strobes
`timescale 1ns/1ps
module adcsr_ahb_slave
  import adcsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr
);
  typedef struct packed {
    adcsr_req_t req;
  } adcsr_slv_t;

  adcsr_slv_t s_q;
  adcsr_slv_t s_d;

  always_comb begin
    s_d = s_q;
    if (hready) begin
      s_d.req.sel = hsel && htrans[1];
      s_d.req.write = hwrite;
      s_d.req.addr = {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // writes finish in one data cycle; the top adds one wait state to reads
  assign wr_stb = s_q.req.sel && s_q.req.write;
  assign rd_stb = s_q.req.sel && !s_q.req.write;
  assign addr = s_q.req.addr;
endmodule

// ==== bench/adcsr_conv_model.sv ====
// stand-in for the conversion cell and the receive dma channel
`timescale 1ns/1ps
module adcsr_conv_model
  import adcsr_pkg::*;
(
  input wire logic clk,
  output adcsr_conv_t conv,
  output logic rx_xfer
);
  initial begin
    conv = '0;
    rx_xfer = 1'b0;
  end
  // ------------------------------
  // conversion end, prompt or late
  // ------------------------------
  task automatic convert(input logic [2:0] ch, input logic [DW-1:0] v, input logic ovr, input logic gov,
                         input int dly);
    repeat (dly) @(posedge clk);
    conv <= '{done: 1'b1, chan: ch, value: v, overrun: ovr, gen_overrun: gov};
    @(posedge clk);
    // idle bus shows inverted junk, so a stale copy never passes
    conv <= '{done: 1'b0, chan: ~ch, value: ~v, overrun: 1'b0, gen_overrun: 1'b0};
  endtask
  task automatic xfer();
    @(posedge clk);
    rx_xfer <= 1'b1;
    @(posedge clk);
    rx_xfer <= 1'b0;
  endtask
endmodule

// ==== bench/adcsr_tb_top.sv ====
// self-checking bench: register traffic, converter events, interrupt line
`timescale 1ns/1ps
module adcsr_tb_top
  import adcsr_pkg::*;
;
  logic CLK, RESETN, HSEL, HWRITE, RDY, HRESP, IRQ, RX_XFER, RESOLUTION_SELECT;
  logic [31:0] HADDR, HWDATA, HRDATA, got, e;
  logic [1:0] HTRANS;
  logic [7:0] CHAN_ENABLE;
  logic [15:0] RX_COUNT;
  logic [2:0] take;
  logic [DW-1:0] v;
  logic [DW-1:0] vs[NCH];
  logic [31:0] exp_q[$];
  adcsr_conv_t conv;
  int errors, checked;

  adcsr_top dut_u (
    .CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'b010), .HREADY(RDY), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(RDY), .HRESP(HRESP),
    .CONV_DONE(conv.done), .CONV_CHAN(conv.chan), .CONV_VALUE(conv.value), .CONV_OVERRUN(conv.overrun),
    .CONV_GEN_OVERRUN(conv.gen_overrun), .RX_XFER(RX_XFER), .CHAN_ENABLE(CHAN_ENABLE),
    .RESOLUTION_SELECT(RESOLUTION_SELECT), .RX_COUNT(RX_COUNT), .IRQ(IRQ)
  );
  adcsr_conv_model m_u (.clk(CLK), .conv(conv), .rx_xfer(RX_XFER));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // ------------------------------
  // bus master and expectation notes
  // ------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'b10;
    do @(posedge CLK); while (RDY !== 1'b1 && ++n < 50);
    HTRANS <= 2'b00;
    HSEL <= 1'b0;
    HWDATA <= d;
    do @(posedge CLK); while (RDY !== 1'b1 && ++n < 50);
    // a slave that never answers counts as a mismatch
    if (n >= 50) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, 32'h0, 32'h1);
    end
  endtask
  task automatic chk(input logic [2:0] sel, input logic [31:0] x);
    exp_q.push_back(x);
    take <= sel;
    @(posedge CLK);
    take <= 3'd0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(a, 1'b0, 32'h0);
    chk(3'd1, x);
  endtask
  // extra edge keeps take from being driven twice in one step
  task automatic look(input logic [2:0] sel, input logic [31:0] x);
    @(posedge CLK);
    chk(sel, x);
  endtask
  // ------------------------------
  // watcher: oldest note against what the outputs show
  // ------------------------------
  always @(posedge CLK) begin
    if (take != 3'd0) begin
      case (take)
        3'd1: got = HRDATA;
        3'd2: got = {31'h0, IRQ};
        3'd3: got = {24'h0, CHAN_ENABLE};
        3'd4: got = {16'h0, RX_COUNT};
        default: got = {31'h0, RESOLUTION_SELECT};
      endcase
      e = exp_q.pop_front();
      checked++;
      if (got !== e) begin
        errors++;
        $display("unexpected at %0t: got %h expected %h", $time, got, e);
      end
    end
  end
  task automatic test_done();
    $display("comparisons %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    RESETN = 1'b0; HSEL = 1'b0; HADDR = '0; HTRANS = '0; HWRITE = 1'b0; HWDATA = '0; take = '0;
    void'($urandom(12169));
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(OFS_CH_STATE, 32'h0);
    rd(OFS_FLAGS, 32'h000c_0000);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_LATEST, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0);
    wr(OFS_CH_ON, 32'h0000_00a5);
    wr(OFS_CH_OFF, 32'h0000_0005);
    rd(OFS_CH_STATE, 32'h0000_00a0);
    look(3'd3, 32'ha0);
    wr(OFS_IRQ_SET, 32'h0001_0080);
    wr(OFS_IRQ_CLR, 32'h0000_0080);
    rd(OFS_IRQ_MASK, 32'h0001_0000);
    look(3'd2, 32'h0);
    v = 10'($urandom);
    m_u.convert(3'd0, ~v, 1'b0, 1'b0, 1);
    m_u.convert(3'd7, v, 1'b0, 1'b0, 4);
    look(3'd2, 32'h1);
    rd(OFS_FLAGS, 32'h000d_0080);
    rd(OFS_RESULT0, 32'h0);
    rd(OFS_RESULT7, {22'h0, v});
    rd(OFS_LATEST, {22'h0, v});
    look(3'd2, 32'h0);
    rd(OFS_FLAGS, 32'h000c_0000);
    m_u.convert(3'd5, v, 1'b1, 1'b1, 1);
    rd(OFS_FLAGS, 32'h000f_2020);
    rd(OFS_FLAGS, 32'h000d_0020);
    wr(OFS_CH_OFF, 32'h0000_0020);
    rd(OFS_FLAGS, 32'h000d_0000);
    rd(OFS_LATEST, {22'h0, v});
    wr(OFS_RX_NCNT, 32'h1);
    rd(OFS_FLAGS, 32'h0);
    wr(OFS_RX_CNT, 32'h1);
    look(3'd4, 32'h1);
    wr(OFS_IRQ_SET, 32'h0004_0000);
    m_u.xfer();
    rd(OFS_FLAGS, 32'h0004_0000);
    look(3'd2, 32'h1);
    m_u.xfer();
    rd(OFS_FLAGS, 32'h000c_0000);
    wr(OFS_IRQ_CLR, 32'h0005_0000);
    look(3'd2, 32'h0);
    wr(OFS_MODE, 32'h1 << POS_RESOLUTION_SELECT);
    look(3'd5, 32'h1);
    wr(OFS_CH_ON, 32'h0000_00ff);
    for (int i = 0; i < NCH; i++) begin
      vs[i] = 10'($urandom);
      m_u.convert(3'(i), vs[i], 1'b0, 1'b0, 1 + i % 3);
    end
    for (int i = 0; i < NCH; i++) begin
      rd(OFS_RESULT0 + 8'(4 * i), {24'h0, vs[i][7:0]});
    end
    rd(OFS_LATEST, {24'h0, vs[7][7:0]});
    wr(OFS_MODE, 32'h0);
    m_u.convert(3'd2, v, 1'b0, 1'b0, 1);
    rd(OFS_RESULT0 + 8'h08, {22'h0, v});
    repeat (3) @(posedge CLK);
    test_done();
  end
  // a full run is a few hundred cycles; far past that means a hang
  initial begin
    #1000000;
    errors++;
    test_done();
  end
endmodule
